// *** rtl/intc_regs_pkg.sv ***
// constants of the interrupt priority and sense register block
package intc_regs_pkg;
   // ***********************************************************
   // register bus
   // ***********************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [3:0] ADDR_PRIO_A = 4'h0;
   localparam logic [3:0] ADDR_PRIO_L = 4'hb;
   localparam logic [3:0] ADDR_CTRL   = 4'hc;
   localparam logic [3:0] ADDR_STATUS = 4'hd;
   // ***********************************************************
   // field layout
   // ***********************************************************
   localparam int NUM_PRIO     = 12;
   localparam int FIELD_W      = 4;
   localparam int FIELDS_PER   = 4;
   localparam int NUM_FIELDS   = 48;
   localparam int NUM_IRQ      = 8;
   localparam int NUM_PERIPH   = 40;
   localparam int NUM_SHARED   = 4;
   localparam int SRC_W        = 7;
   localparam int SHARED_FIELD [NUM_SHARED] = '{8, 9, 37, 38};
   localparam int CTRL_NMI_LEVEL_BIT = 15;
   localparam int CTRL_NMI_EDGE_BIT  = 8;
   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [15:0] PRIO_RESET  = 16'h0000;
   localparam logic [7:0]  SENSE_RESET = 8'h00;
   localparam logic [7:0]  FLAG_RESET  = 8'h00;
   localparam logic        EDGE_RESET  = 1'b0;
endpackage

// *** rtl/intc_regs.sv ***
// interrupt priority, sense control and request flag registers with arbitration
// ***********************************************************
// ***********************************************************
module intc_regs (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        hw_standby_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   input  wire logic        nmi_pin_i,
   input  wire logic [7:0]  ext_request_n_i,
   input  wire logic [39:0] periph_req_i,
   input  wire logic [3:0]  periph_shared_req_i,
   input  wire logic [3:0]  cpu_mask_level_i,
   input  wire logic        cpu_ack_i,
   output logic             cpu_request_o,
   output logic      [3:0]  cpu_level_o,
   output logic      [6:0]  cpu_source_o,
   output logic             nmi_request_o,
   output logic             interrupt_accepted_out_n_o
);
   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [7:0]        irq_m;
      logic [7:0]        irq_s;
      logic [7:0]        irq_p;
      logic              nmi_m;
      logic              nmi_s;
      logic              nmi_p;
      logic [11:0][15:0] prio;
      logic              nmi_edge;
      logic [7:0]        sense;
      logic [7:0]        flag;
      logic [7:0]        seen;
      logic [15:0]       rdata;
      logic              nmi_req;
      logic              req;
      logic [3:0]        lvl;
      logic [6:0]        src;
      logic              acc_n;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      logic [7:0]  view;
      logic [7:0]  fall;
      logic [7:0]  clr;
      logic [7:0]  pend;
      logic [15:0] ctrl;
      logic        valid;
      logic        p;
      logic [3:0]  best;
      logic [3:0]  lv;
      logic [6:0]  bsrc;
      int          b;
      view  = '0;
      fall  = '0;
      clr   = '0;
      pend  = '0;
      ctrl  = '0;
      valid = 1'b0;
      p     = 1'b0;
      best  = '0;
      lv    = '0;
      bsrc  = '0;
      b     = 0;
      s_d   = s_q;
      // two-stage pin synchronisers
      s_d.irq_m = ext_request_n_i;
      s_d.irq_s = s_q.irq_m;
      s_d.irq_p = s_q.irq_s;
      s_d.nmi_m = nmi_pin_i;
      s_d.nmi_s = s_q.nmi_m;
      s_d.nmi_p = s_q.nmi_s;
      // nonmaskable edge detect
      if (s_q.nmi_edge) begin
         s_d.nmi_req = s_q.nmi_s & ~s_q.nmi_p;
      end else begin
         s_d.nmi_req = s_q.nmi_p & ~s_q.nmi_s;
      end
      // per input view, bit 7 is input 0
      for (int n = 0; n < intc_regs_pkg::NUM_IRQ; n++) begin
         b = 7 - n;
         fall[b] = s_q.irq_p[n] & ~s_q.irq_s[n] & s_q.sense[b];
         if (s_q.sense[b]) begin
            view[b] = s_q.flag[b];
         end else begin
            view[b] = ~s_q.irq_s[n];
         end
         pend[n] = view[b];
      end
      ctrl[intc_regs_pkg::CTRL_NMI_LEVEL_BIT] = s_q.nmi_s;
      ctrl[intc_regs_pkg::CTRL_NMI_EDGE_BIT]  = s_q.nmi_edge;
      ctrl[7:0] = s_q.sense;
      // register writes
      if (wr_i) begin
         if (addr_i <= intc_regs_pkg::ADDR_PRIO_L) begin
            s_d.prio[addr_i] = wdata_i;
         end else if (addr_i == intc_regs_pkg::ADDR_CTRL) begin
            s_d.nmi_edge = wdata_i[intc_regs_pkg::CTRL_NMI_EDGE_BIT];
            s_d.sense    = wdata_i[7:0];
         end else if (addr_i == intc_regs_pkg::ADDR_STATUS) begin
            clr = s_q.seen & s_q.sense & ~wdata_i[7:0];
         end
      end
      // register reads, data in the next cycle only
      s_d.rdata = '0;
      if (rd_i) begin
         if (addr_i <= intc_regs_pkg::ADDR_PRIO_L) begin
            s_d.rdata = s_q.prio[addr_i];
         end else if (addr_i == intc_regs_pkg::ADDR_CTRL) begin
            s_d.rdata = ctrl;
         end else if (addr_i == intc_regs_pkg::ADDR_STATUS) begin
            s_d.rdata = {8'h00, view};
            s_d.seen  = s_q.seen | (view & s_q.sense);
         end
      end
      // exception processing of an edge input
      if (cpu_ack_i && s_q.req && !s_q.src[0] && s_q.src[6:1] < 6'd8) begin
         b = 7 - int'(s_q.src[6:1]);
         clr[b] = clr[b] | s_q.sense[b];
      end
      // set wins over clear
      s_d.flag = ((s_q.flag & ~clr) | fall) & s_q.sense;
      s_d.seen = s_d.seen & s_d.flag;
      // arbitration over fields in default order
      for (int f = 0; f < intc_regs_pkg::NUM_FIELDS; f++) begin
         lv = s_q.prio[f / 4][15 - 4 * (f % 4) -: 4];
         for (int k = 0; k < 2; k++) begin
            p = 1'b0;
            if (k == 0) begin
               if (f < intc_regs_pkg::NUM_IRQ) begin
                  p = pend[f];
               end else begin
                  p = periph_req_i[f - intc_regs_pkg::NUM_IRQ];
               end
            end else begin
               for (int j = 0; j < intc_regs_pkg::NUM_SHARED; j++) begin
                  if (intc_regs_pkg::SHARED_FIELD[j] == f) begin
                     p = periph_shared_req_i[j];
                  end
               end
            end
            // strictly greater only, so earlier sources win ties
            if (p && (!valid || lv > best)) begin
               valid = 1'b1;
               best  = lv;
               bsrc  = 7'(2 * f + k);
            end
         end
      end
      s_d.req   = valid && (best > cpu_mask_level_i);
      s_d.lvl   = s_d.req ? best : 4'h0;
      s_d.src   = s_d.req ? bsrc : 7'h00;
      s_d.acc_n = ~s_d.req;
      // hardware standby clears prio, nmi_edge, sense, flag and seen like reset
      if (hw_standby_i) begin
         s_d.prio     = {intc_regs_pkg::NUM_PRIO{intc_regs_pkg::PRIO_RESET}};
         s_d.nmi_edge = intc_regs_pkg::EDGE_RESET;
         s_d.sense    = intc_regs_pkg::SENSE_RESET;
         s_d.flag     = intc_regs_pkg::FLAG_RESET;
         s_d.seen     = '0;
      end
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s_q       <= '0;
         s_q.acc_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o                    = s_q.rdata;
   assign cpu_request_o              = s_q.req;
   assign cpu_level_o                = s_q.lvl;
   assign cpu_source_o               = s_q.src;
   assign nmi_request_o              = s_q.nmi_req;
   assign interrupt_accepted_out_n_o = s_q.acc_n;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   sequence s_wr_prio_a;
      wr_i && addr_i == intc_regs_pkg::ADDR_PRIO_A && !hw_standby_i;
   endsequence
   sequence s_rd_prio_a;
      rd_i && addr_i == intc_regs_pkg::ADDR_PRIO_A && !hw_standby_i;
   endsequence
   sequence s_saw_flag0;
      rd_i && addr_i == intc_regs_pkg::ADDR_STATUS && s_q.sense[7] && s_q.flag[7];
   endsequence
   sequence s_clear_flag0;
      wr_i && addr_i == intc_regs_pkg::ADDR_STATUS && !wdata_i[7] && s_q.sense[7]
         && !(s_q.irq_p[0] && !s_q.irq_s[0]) && !hw_standby_i;
   endsequence

   a_prio_readback: assert property (s_wr_prio_a ##1 s_rd_prio_a |=>
      rdata_o == $past(wdata_i, 2))
      else $error("priority register did not read back");
   a_nmi_level_bit: assert property (rd_i && addr_i == intc_regs_pkg::ADDR_CTRL |=>
      rdata_o[15] == $past(s_q.nmi_s))
      else $error("control bit 15 differs from pin level");
   a_reserved_read_zero: assert property (rd_i && addr_i >= intc_regs_pkg::ADDR_CTRL |=>
      rdata_o[14:9] == 6'h00 && (!$past(addr_i[0]) || rdata_o[15:8] == 8'h00))
      else $error("reserved bits read nonzero");
   a_standby_clears: assert property (hw_standby_i |=>
      s_q.prio == '0 && s_q.sense == 8'h00 && !s_q.nmi_edge && s_q.flag == 8'h00)
      else $error("standby left registers set");
   a_level_follows: assert property (rd_i && addr_i == intc_regs_pkg::ADDR_STATUS
      && !s_q.sense[7] |=> rdata_o[7] == !$past(s_q.irq_s[0]))
      else $error("level flag does not follow input");
   a_edge_sets_flag: assert property (s_q.sense[7] && s_q.irq_p[0] && !s_q.irq_s[0]
      && !hw_standby_i |=> s_q.flag[7])
      else $error("falling edge did not set flag");
   a_read_write_clear: assert property (s_saw_flag0 ##1 s_clear_flag0
      |=> !s_q.flag[7])
      else $error("read then write zero did not clear flag");
   a_ack_clears_flag: assert property (cpu_ack_i && s_q.req && s_q.src == 7'h00
      && s_q.sense[7] && !(s_q.irq_p[0] && !s_q.irq_s[0]) |=> !s_q.flag[7])
      else $error("exception processing did not clear flag");
   a_mask_gate: assert property (cpu_request_o |->
      cpu_level_o > $past(cpu_mask_level_i))
      else $error("request forwarded at or below mask");
   a_accept_pin_low: assert property (cpu_request_o |-> !interrupt_accepted_out_n_o
      ##0 (!cpu_request_o [*1] or 1'b1))
      else $error("accepted pin not low with request");
   a_nmi_fall_pulse: assert property (!s_q.nmi_edge && s_q.nmi_p && !s_q.nmi_s
      |=> nmi_request_o ##1 (!nmi_request_o || $past(s_q.nmi_p && !s_q.nmi_s)))
      else $error("nonmaskable falling edge not reported once");
endmodule

// *** test/cpu_model.sv ***
// cpu core model that acknowledges forwarded requests
module cpu_model (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       request_i,
   input  wire logic [3:0] delay_i,
   output logic            ack_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   // ***********************************************************
   // one ack pulse after delay_i + 1 cycles of a standing request
   // ***********************************************************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 4'h0;
         ack_o  <= 1'b0;
      end else begin
         ack_o <= 1'b0;
         if (!request_i || ack_o) begin
            wait_q <= 4'h0;
         end else if (wait_q == delay_i) begin
            ack_o  <= 1'b1;
            wait_q <= 4'h0;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule

// *** test/tb_top.sv ***
// testbench of the interrupt priority and sense registers
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_t;
   logic        clock_i, rst_i, hw_standby_i, wr_i, rd_i, nmi_pin_i, cpu_ack_i;
   logic        cpu_request_o, nmi_request_o, interrupt_accepted_out_n_o;
   logic [3:0]  addr_i, cpu_mask_level_i, cpu_level_o, periph_shared_req_i, ack_delay;
   logic [15:0] wdata_i, rdata_o;
   logic [7:0]  ext_request_n_i;
   logic [39:0] periph_req_i;
   logic [6:0]  cpu_source_o;
   int          fail_count, checks, n;
   row_t        rows [7] = '{'{4'h0, 16'h1234, 16'h1234}, '{4'hb, 16'hfedc, 16'hfedc},
      '{4'h5, 16'h0f0f, 16'h0f0f}, '{4'hc, 16'h81ff, 16'h81ff}, '{4'he, 16'hffff, 16'h0000},
      '{4'hd, 16'h00ff, 16'h0000}, '{4'hc, 16'h0000, 16'h8000}};
   intc_regs uut (.clock_i(clock_i), .rst_i(rst_i), .hw_standby_i(hw_standby_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .nmi_pin_i(nmi_pin_i), .ext_request_n_i(ext_request_n_i), .periph_req_i(periph_req_i),
      .periph_shared_req_i(periph_shared_req_i), .cpu_mask_level_i(cpu_mask_level_i),
      .cpu_ack_i(cpu_ack_i), .cpu_request_o(cpu_request_o), .cpu_level_o(cpu_level_o),
      .cpu_source_o(cpu_source_o), .nmi_request_o(nmi_request_o),
      .interrupt_accepted_out_n_o(interrupt_accepted_out_n_o));
   cpu_model cpu (.clock_i(clock_i), .rst_i(rst_i), .request_i(cpu_request_o),
      .delay_i(ack_delay), .ack_o(cpu_ack_i));
   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task report_and_stop;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp);
   endtask
   task pin(input logic [7:0] v);
      @(posedge clock_i);
      ext_request_n_i <= v;
      repeat (6) @(posedge clock_i);
      #1;
   endtask
   task nmi_step(input logic v, input int exp);
      int cnt;
      cnt = 0;
      @(posedge clock_i);
      nmi_pin_i <= v;
      repeat (6) begin
         @(posedge clock_i);
         #1 if (nmi_request_o === 1'b1) cnt++;
      end
      chk(16'(cnt), 16'(exp));
   endtask
   // ***********************************************************
   // clock, watchdog and tests
   // ***********************************************************
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   initial begin
      repeat (3000) @(posedge clock_i);
      fail_count++;
      report_and_stop;
   end
   initial begin
      {rst_i, nmi_pin_i, ext_request_n_i} = 10'h3ff;
      {hw_standby_i, wr_i, rd_i, addr_i, wdata_i, periph_req_i, periph_shared_req_i} = '0;
      cpu_mask_level_i = 4'h0;
      ack_delay = 4'h2;
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      #1 chk(interrupt_accepted_out_n_o, 1'b1);
      for (n = 0; n < 14; n++) rd(n[3:0], (n == 12) ? 16'h8000 : 16'h0000);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      wr(4'h0, 16'h5000);
      cpu_mask_level_i <= 4'h4;
      pin(8'hfe);
      chk({cpu_request_o, cpu_level_o, cpu_source_o}, {1'b1, 4'h5, 7'h00});
      chk(interrupt_accepted_out_n_o, 1'b0);
      rd(4'hd, 16'h0080);
      cpu_mask_level_i <= 4'h5;
      pin(8'hfe);
      chk(cpu_request_o, 1'b0);
      pin(8'hff);
      rd(4'hd, 16'h0000);
      wr(4'h2, 16'h5000);
      cpu_mask_level_i <= 4'h2;
      periph_shared_req_i <= 4'h1;
      pin(8'hff);
      chk({cpu_level_o, cpu_source_o}, {4'h5, 7'h11});
      periph_req_i <= 40'h1;
      pin(8'hff);
      chk(cpu_source_o, 7'h10);
      periph_req_i <= 40'h0;
      periph_shared_req_i <= 4'h0;
      wr(4'hc, 16'h0080);
      cpu_mask_level_i <= 4'hf;
      pin(8'hfe);
      pin(8'hff);
      wr(4'hd, 16'h0000);
      rd(4'hd, 16'h0080);
      wr(4'hd, 16'h0000);
      rd(4'hd, 16'h0000);
      ack_delay <= 4'h6;
      cpu_mask_level_i <= 4'h4;
      pin(8'hfe);
      pin(8'hff);
      rd(4'hd, 16'h0000);
      chk(cpu_request_o, 1'b0);
      nmi_step(1'b0, 1);
      nmi_step(1'b1, 0);
      wr(4'hc, 16'h0100);
      nmi_step(1'b0, 0);
      nmi_step(1'b1, 1);
      @(posedge clock_i);
      hw_standby_i <= 1'b1;
      @(posedge clock_i);
      hw_standby_i <= 1'b0;
      rd(4'h0, 16'h0000);
      rd(4'hc, 16'h8000);
      report_and_stop;
   end
endmodule
